// *** logic/sla_pkg.sv ***
// constants, pin carrier and access record for the serial link parallel adaptor
// assumes a single 250 MHz core clock; bit times are counted in core cycles
package sla_pkg;
	// ------------------------------------------------------------
	// clock and link timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int BIT_NS_SLOW = 100;
	localparam int BIT_NS_FAST = 50;
	localparam logic [9:0] BIT_CYC_SLOW = 10'(BIT_NS_SLOW * CLK_MHZ / 1000);
	localparam logic [9:0] BIT_CYC_FAST = 10'(BIT_NS_FAST * CLK_MHZ / 1000);
	localparam int IN_DONE_DROP_BITS = 2;
	localparam int OUT_STROBE_DROP_BITS = 2;
	localparam int OUT_BYTE_HOLD_BITS = 11;
	localparam logic [7:0] STRAP_CYC = 8'h80;
	localparam logic [3:0] PKT_DATA_BITS = 4'hB;
	localparam logic [3:0] PKT_ACK_BITS = 4'h2;
	localparam logic [3:0] RX_DATA_BITS = 4'h8;
	localparam int RX_FIFO_DEPTH = 8;
	localparam int BYTE_W = 8;

	// ------------------------------------------------------------
	// bus-mode register map
	// ------------------------------------------------------------
	localparam logic [1:0] REG_RX_DATA = 2'h0;
	localparam logic [1:0] REG_TX_DATA = 2'h1;
	localparam logic [1:0] REG_RX_STAT = 2'h2;
	localparam logic [1:0] REG_TX_STAT = 2'h3;
	localparam int STAT_FLAG_BIT = 0;
	localparam int STAT_IE_BIT = 1;
	localparam logic RX_PRESENT_RESET = 1'b0;
	localparam logic TX_READY_RESET = 1'b1;
	localparam logic IE_RESET = 1'b0;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic rx;
		logic mode_pin;
		logic rate_pin;
		logic [7:0] in_byte;
		logic in_strobe;
		logic out_taken;
		logic [7:0] bus_data;
		logic cs_n;
		logic rd;
		logic [1:0] sel;
	} sla_pins_s;

	typedef struct packed {
		logic [1:0] sel;
		logic rd;
	} sla_access_s;
endpackage

// *** logic/sla_fifo.sv ***
// small first-word-fall-through fifo in flip-flops
// assumes both sides on one clock; valid/ready on each side
`timescale 1ns/1ns
module sla_fifo import sla_pkg::*; #(
	parameter int WIDTH = BYTE_W,
	parameter int DEPTH = RX_FIFO_DEPTH
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	assign out_valid_o = wr_q != rd_q;
	assign in_ready_o = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end
endmodule

// *** logic/sla_link_rx.sv ***
// link receiver: splits incoming traffic into data bytes and acknowledges
// assumes rx_i is already synchronised; bit length given in core cycles
`timescale 1ns/1ns
module sla_link_rx import sla_pkg::*; (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic rx_i,
	input wire logic [9:0] bit_cyc_i,
	output logic ack_o,
	output logic data_valid_o,
	input wire logic data_ready_i,
	output logic [7:0] data_o
);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_KIND, RX_DATA, RX_STOP, RX_TAIL} sla_rx_e;

	sla_rx_e st_q;
	logic prev_q;
	logic [9:0] tmr_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic tick;

	assign tick = tmr_q == 10'h000;

	// ------------------------------------------------------------
	// packet framing, sampled mid-bit
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= RX_IDLE;
			prev_q <= 1'b0;
			tmr_q <= 10'h000;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ack_o <= 1'b0;
		end else begin
			prev_q <= rx_i;
			ack_o <= 1'b0;
			if (!tick) begin
				tmr_q <= tmr_q - 1'b1;
			end
			unique case (st_q)
				RX_IDLE: begin
					if (rx_i && !prev_q) begin
						tmr_q <= bit_cyc_i >> 1;
						st_q <= RX_START;
					end
				end
				RX_START: begin
					if (tick) begin
						tmr_q <= bit_cyc_i - 1'b1;
						st_q <= rx_i ? RX_KIND : RX_IDLE;
					end
				end
				RX_KIND: begin
					if (tick) begin
						tmr_q <= bit_cyc_i - 1'b1;
						cnt_q <= 4'h0;
						ack_o <= !rx_i;
						st_q <= rx_i ? RX_DATA : RX_IDLE;
					end
				end
				RX_DATA: begin
					if (tick) begin
						tmr_q <= bit_cyc_i - 1'b1;
						sh_q <= {rx_i, sh_q[7:1]};
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == RX_DATA_BITS - 1'b1) begin
							st_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					// one extra bit after the stop sample puts delivery past 11.5 bits
					if (tick) begin
						tmr_q <= bit_cyc_i - 1'b1;
						st_q <= RX_TAIL;
					end
				end
				RX_TAIL: begin
					if (tick) begin
						st_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// delivered byte; a second byte before the first is taken is lost
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			data_valid_o <= 1'b0;
			data_o <= 8'h00;
		end else begin
			if (data_valid_o && data_ready_i) begin
				data_valid_o <= 1'b0;
			end
			if (st_q == RX_TAIL && tick && !data_valid_o) begin
				data_valid_o <= 1'b1;
				data_o <= sh_q;
			end
		end
	end
endmodule

// *** logic/sla_adaptor.sv ***
// serial link adaptor: byte link on one side, handshake ports or a small bus on the other
// assumes all pins are asynchronous to core_clk_i; mode strap settles before reset release
`timescale 1ns/1ns
module sla_adaptor import sla_pkg::*; #(
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic serial_rx_i,
	output logic serial_tx_o,
	input wire logic mode_speed_pin_i,
	input wire logic bit_rate_pin_i,
	input wire logic [7:0] in_port_byte_i,
	input wire logic in_port_strobe_i,
	output logic in_port_done_o,
	output logic [7:0] peripheral_out_byte_o,
	output logic out_port_strobe_o,
	input wire logic out_port_taken_i,
	input wire logic [7:0] host_data_bus_i,
	output logic [7:0] host_data_bus_o,
	output logic host_data_bus_oe_o,
	input wire logic chip_select_n_i,
	input wire logic read_write_sel_i,
	input wire logic [1:0] register_select_i
);
	typedef enum logic [1:0] {IN_IDLE, IN_WAIT, IN_DONE, IN_DROP} sla_in_e;
	typedef enum logic [1:0] {OUT_IDLE, OUT_WAIT, OUT_LOWER, OUT_RELEASE} sla_out_e;

	sla_pins_s pin_raw;
	sla_pins_s sync1_q;
	sla_pins_s sync2_q;
	sla_pins_s prev_q;
	sla_access_s acc_q;
	sla_in_e in_st_q;
	sla_out_e out_st_q;

	logic [7:0] strap_cnt_q;
	logic seen_hi_q;
	logic seen_lo_q;
	logic strap_done;
	logic mode1;
	logic fast;
	logic [9:0] bit_cyc;

	logic rx_ack;
	logic rx_valid;
	logic rx_ready;
	logic [7:0] rx_byte;
	logic fifo_valid;
	logic fifo_pop;
	logic [7:0] fifo_byte;

	logic data_req;
	logic ack_req;
	logic ack_ok;
	logic pend_data_q;
	logic pend_ack_q;
	logic await_ack_q;
	logic [7:0] tx_byte_q;
	logic tx_busy_q;
	logic [9:0] tx_shift_q;
	logic [3:0] tx_cnt_q;
	logic [9:0] tx_tmr_q;
	logic [9:0] gap_q;
	logic tx_start_ack;
	logic tx_start_data;

	logic [9:0] in_tmr_q;
	logic [9:0] out_tmr_q;
	logic [7:0] out_byte_q;

	logic bus_active_q;
	logic cs_fall;
	logic cs_rise;
	logic wr_tx_data;
	logic rd_rx_data;
	logic present_q;
	logic rx_ie_q;
	logic out_ready_q;
	logic tx_ie_q;
	logic [7:0] rd_data_q;

	function automatic logic [9:0] bits_cyc(input logic [9:0] bc, input int n);
		bits_cyc = 10'(int'(bc) * n);
	endfunction

	function automatic logic [7:0] reg_read(input logic [1:0] sel);
		logic [7:0] r;
		r = 8'h00;
		unique case (sel)
			REG_RX_DATA: r = out_byte_q;
			REG_TX_DATA: r = 8'h00;
			REG_RX_STAT: begin
				r[STAT_FLAG_BIT] = present_q;
				r[STAT_IE_BIT] = rx_ie_q;
			end
			REG_TX_STAT: begin
				r[STAT_FLAG_BIT] = out_ready_q;
				r[STAT_IE_BIT] = tx_ie_q;
			end
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers and edge history
	// ------------------------------------------------------------
	assign pin_raw = {serial_rx_i, mode_speed_pin_i, bit_rate_pin_i, in_port_byte_i, in_port_strobe_i,
		out_port_taken_i, host_data_bus_i, chip_select_n_i, read_write_sel_i, register_select_i};

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// ------------------------------------------------------------
	// strap: steady high, toggling, or steady low after reset
	// ------------------------------------------------------------
	// the window must span several periods of a toggling strap
	assign strap_done = strap_cnt_q == STRAP_CYC;
	assign mode1 = seen_hi_q;
	assign fast = mode1 ? seen_lo_q : sync2_q.rate_pin;
	assign bit_cyc = fast ? BIT_CYC_FAST : BIT_CYC_SLOW;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_cnt_q <= 8'h00;
			seen_hi_q <= 1'b0;
			seen_lo_q <= 1'b0;
		end else if (!strap_done) begin
			strap_cnt_q <= strap_cnt_q + 1'b1;
			// first two counts still see the synchroniser's reset value, not the strap
			if (strap_cnt_q > 8'h01) begin
				seen_hi_q <= seen_hi_q | sync2_q.mode_pin;
				seen_lo_q <= seen_lo_q | !sync2_q.mode_pin;
			end
		end
	end

	// ------------------------------------------------------------
	// receive path
	// ------------------------------------------------------------
	sla_link_rx u_rx (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.rx_i(sync2_q.rx),
		.bit_cyc_i(bit_cyc),
		.ack_o(rx_ack),
		.data_valid_o(rx_valid),
		.data_ready_i(rx_ready),
		.data_o(rx_byte)
	);

	sla_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.in_valid_i(rx_valid),
		.in_ready_o(rx_ready),
		.in_data_i(rx_byte),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_byte)
	);

	// acknowledge goes out only when the popped byte is taken at the output port or on any REG_RX_DATA read, byte present or not, so the far end paces itself
	assign fifo_pop = fifo_valid && strap_done && (mode1 ? out_st_q == OUT_IDLE : !present_q);

	// ------------------------------------------------------------
	// transmit path
	// ------------------------------------------------------------
	assign data_req = (mode1 && strap_done && in_st_q == IN_IDLE && sync2_q.in_strobe) || wr_tx_data;
	assign ack_req = (out_st_q == OUT_WAIT && sync2_q.out_taken) || rd_rx_data;
	assign ack_ok = rx_ack && await_ack_q;
	assign tx_start_ack = !tx_busy_q && strap_done && gap_q == 10'h000 && pend_ack_q;
	assign tx_start_data = !tx_busy_q && strap_done && gap_q == 10'h000 && pend_data_q && !pend_ack_q;
	assign serial_tx_o = tx_busy_q & tx_shift_q[0];

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pend_data_q <= 1'b0;
			pend_ack_q <= 1'b0;
			await_ack_q <= 1'b0;
			tx_byte_q <= 8'h00;
			gap_q <= 10'h000;
		end else begin
			pend_ack_q <= (pend_ack_q && !tx_start_ack) || ack_req;
			pend_data_q <= (pend_data_q && !tx_start_data) || data_req;
			if (tx_start_data) begin
				await_ack_q <= 1'b1;
			end else if (rx_ack) begin
				await_ack_q <= 1'b0;
			end
			if (wr_tx_data) begin
				tx_byte_q <= sync2_q.bus_data;
			end else if (data_req) begin
				tx_byte_q <= sync2_q.in_byte;
			end
			// a fresh request waits one bit before the start bit goes out
			if (!pend_ack_q && !pend_data_q) begin
				gap_q <= bit_cyc;
			end else if (gap_q != 10'h000) begin
				gap_q <= gap_q - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_busy_q <= 1'b0;
			tx_shift_q <= 10'h000;
			tx_cnt_q <= 4'h0;
			tx_tmr_q <= 10'h000;
		end else if (tx_start_ack) begin
			tx_busy_q <= 1'b1;
			tx_shift_q <= 10'h001;
			tx_cnt_q <= PKT_ACK_BITS - 1'b1;
			tx_tmr_q <= bit_cyc - 1'b1;
		end else if (tx_start_data) begin
			tx_busy_q <= 1'b1;
			tx_shift_q <= {tx_byte_q, 2'b11};
			tx_cnt_q <= PKT_DATA_BITS - 1'b1;
			tx_tmr_q <= bit_cyc - 1'b1;
		end else if (tx_busy_q) begin
			if (tx_tmr_q != 10'h000) begin
				tx_tmr_q <= tx_tmr_q - 1'b1;
			end else if (tx_cnt_q == 4'h0) begin
				tx_busy_q <= 1'b0;
			end else begin
				tx_shift_q <= {1'b0, tx_shift_q[9:1]};
				tx_cnt_q <= tx_cnt_q - 1'b1;
				tx_tmr_q <= bit_cyc - 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// handshake input port
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			in_st_q <= IN_IDLE;
			in_port_done_o <= 1'b0;
			in_tmr_q <= 10'h000;
		end else begin
			unique case (in_st_q)
				IN_IDLE: begin
					if (data_req && !wr_tx_data) begin
						in_st_q <= IN_WAIT;
					end
				end
				IN_WAIT: begin
					if (ack_ok) begin
						in_port_done_o <= 1'b1;
						in_st_q <= IN_DONE;
					end
				end
				IN_DONE: begin
					if (!sync2_q.in_strobe) begin
						in_tmr_q <= bits_cyc(bit_cyc, IN_DONE_DROP_BITS);
						in_st_q <= IN_DROP;
					end
				end
				IN_DROP: begin
					if (in_tmr_q != 10'h000) begin
						in_tmr_q <= in_tmr_q - 1'b1;
					end else begin
						in_port_done_o <= 1'b0;
						in_st_q <= IN_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// handshake output port
	// ------------------------------------------------------------
	assign peripheral_out_byte_o = out_byte_q;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out_byte_q <= 8'h00;
		end else if (fifo_pop) begin
			out_byte_q <= fifo_byte;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out_st_q <= OUT_IDLE;
			out_port_strobe_o <= 1'b0;
			out_tmr_q <= 10'h000;
		end else begin
			if (out_tmr_q != 10'h000) begin
				out_tmr_q <= out_tmr_q - 1'b1;
			end
			unique case (out_st_q)
				OUT_IDLE: begin
					if (fifo_pop && mode1) begin
						out_port_strobe_o <= 1'b1;
						out_st_q <= OUT_WAIT;
					end
				end
				OUT_WAIT: begin
					if (sync2_q.out_taken) begin
						out_tmr_q <= bits_cyc(bit_cyc, OUT_STROBE_DROP_BITS);
						out_st_q <= OUT_LOWER;
					end
				end
				OUT_LOWER: begin
					if (out_tmr_q == 10'h000) begin
						out_port_strobe_o <= 1'b0;
						out_tmr_q <= bits_cyc(bit_cyc, OUT_BYTE_HOLD_BITS);
						out_st_q <= OUT_RELEASE;
					end
				end
				OUT_RELEASE: begin
					if (out_tmr_q == 10'h000 && !sync2_q.out_taken) begin
						out_st_q <= OUT_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// bus mode register access
	// ------------------------------------------------------------
	assign cs_fall = !mode1 && strap_done && prev_q.cs_n && !sync2_q.cs_n;
	assign cs_rise = bus_active_q && sync2_q.cs_n;
	assign wr_tx_data = cs_rise && !acc_q.rd && acc_q.sel == REG_TX_DATA;
	assign rd_rx_data = cs_rise && acc_q.rd && acc_q.sel == REG_RX_DATA;
	assign host_data_bus_oe_o = bus_active_q && acc_q.rd;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus_active_q <= 1'b0;
			acc_q <= '0;
			rd_data_q <= 8'h00;
		end else begin
			if (cs_fall) begin
				bus_active_q <= 1'b1;
				acc_q <= '{sel: sync2_q.sel, rd: sync2_q.rd};
				rd_data_q <= reg_read(sync2_q.sel);
			end else if (cs_rise) begin
				bus_active_q <= 1'b0;
			end else if (bus_active_q) begin
				rd_data_q <= reg_read(acc_q.sel);
			end
		end
	end

	assign host_data_bus_o = rd_data_q;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			present_q <= RX_PRESENT_RESET;
			rx_ie_q <= IE_RESET;
			out_ready_q <= TX_READY_RESET;
			tx_ie_q <= IE_RESET;
		end else begin
			if (cs_rise && !acc_q.rd && acc_q.sel == REG_RX_STAT) begin
				rx_ie_q <= sync2_q.bus_data[STAT_IE_BIT];
			end
			if (cs_rise && !acc_q.rd && acc_q.sel == REG_TX_STAT) begin
				tx_ie_q <= sync2_q.bus_data[STAT_IE_BIT];
			end
			// set is placed last so a new byte wins over a read in the same cycle
			if (rd_rx_data) begin
				present_q <= 1'b0;
			end
			if (fifo_pop && !mode1) begin
				present_q <= 1'b1;
			end
			if (wr_tx_data) begin
				out_ready_q <= 1'b0;
			end
			if (ack_ok && !mode1) begin
				out_ready_q <= 1'b1;
			end
		end
	end
endmodule

// *** testbench/sla_adaptor_asserts.sv ***
// checker for the adaptor top: handshake, link and bus timing at the pins
// assumes a 10 Mbit/s link on a 250 MHz core clock; bound onto every adaptor
`timescale 1ns/1ns
module sla_adaptor_asserts import sla_pkg::*; #(
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic serial_rx_i,
	input wire logic serial_tx_o,
	input wire logic mode_speed_pin_i,
	input wire logic bit_rate_pin_i,
	input wire logic [7:0] in_port_byte_i,
	input wire logic in_port_strobe_i,
	input wire logic in_port_done_o,
	input wire logic [7:0] peripheral_out_byte_o,
	input wire logic out_port_strobe_o,
	input wire logic out_port_taken_i,
	input wire logic [7:0] host_data_bus_i,
	input wire logic [7:0] host_data_bus_o,
	input wire logic host_data_bus_oe_o,
	input wire logic chip_select_n_i,
	input wire logic read_write_sel_i,
	input wire logic [1:0] register_select_i
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// ------------------------------------------------------------
	// cycles since the output strobe was last high, saturating
	// ------------------------------------------------------------
	logic [8:0] since_fall_q;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			since_fall_q <= 9'h1FF;
		end else if (out_port_strobe_o) begin
			since_fall_q <= 9'h000;
		end else if (since_fall_q != 9'h1FF) begin
			since_fall_q <= since_fall_q + 9'h001;
		end
	end
	sequence s_done_hold;
		in_port_done_o throughout (##24 1'b1);
	endsequence
	sequence s_done_drop;
		##[1:76] !in_port_done_o;
	endsequence
	sequence s_strobe_hold;
		out_port_strobe_o throughout (##44 1'b1);
	endsequence
	a_reset_quiet: assert property ($rose(reset_n_i) |-> !serial_tx_o && !in_port_done_o
		&& !out_port_strobe_o && !host_data_bus_oe_o) else $error("outputs not quiet after reset");
	a_in_send_window: assert property ($rose(in_port_strobe_i) && mode_speed_pin_i && !in_port_done_o
		|-> ##[19:100] $rose(serial_tx_o)) else $error("input byte not sent in time");
	a_done_release: assert property ($fell(in_port_strobe_i) && in_port_done_o
		|-> s_done_hold ##0 s_done_drop) else $error("input done dropped outside window");
	a_ack_send_window: assert property ($rose(out_port_taken_i) && out_port_strobe_o
		|-> ##[19:330] $rose(serial_tx_o)) else $error("acknowledge not sent in time");
	a_strobe_release: assert property ($rose(out_port_taken_i) && out_port_strobe_o
		|-> s_strobe_hold ##[1:100] !out_port_strobe_o) else $error("output strobe dropped outside window");
	a_out_byte_hold: assert property ($changed(peripheral_out_byte_o) |-> !$past(out_port_strobe_o)
		&& $past(since_fall_q) >= 9'h113) else $error("output byte changed too early");
	a_oe_idle: assert property (chip_select_n_i [*5] |-> !host_data_bus_oe_o)
		else $error("bus driven while not selected");
	a_oe_read: assert property ($rose(host_data_bus_oe_o) |-> $past(read_write_sel_i, 2)
		&& !$past(chip_select_n_i, 2) && !mode_speed_pin_i) else $error("bus driven outside a read");
	a_tx_bit_width: assert property ($changed(serial_tx_o) |=> $stable(serial_tx_o) [*8])
		else $error("link bit shorter than a bit time");
endmodule
bind sla_adaptor sla_adaptor_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_asserts (.core_clk_i, .reset_n_i,
	.serial_rx_i, .serial_tx_o, .mode_speed_pin_i, .bit_rate_pin_i, .in_port_byte_i, .in_port_strobe_i,
	.in_port_done_o, .peripheral_out_byte_o, .out_port_strobe_o, .out_port_taken_i, .host_data_bus_i,
	.host_data_bus_o, .host_data_bus_oe_o, .chip_select_n_i, .read_write_sel_i, .register_select_i);

// *** testbench/sla_node_model.sv ***
// link node model: sends data and acknowledge packets, acknowledges each data byte
// assumes a link bit time of BIT_NS; samples mid-bit, unrelated to the core clock
`timescale 1ns/1ns
module sla_node_model #(
	parameter int BIT_NS = 100
) (
	input wire logic tx_i,
	output logic rx_o
);
	logic [7:0] got_byte = 8'h00;
	int n_data = 0;
	int n_ack = 0;
	int ack_wait = 0;
	bit tx_busy = 1'b0;
	initial rx_o = 1'b0;
	// bits go out from index 0 upward, so the byte leaves lsb first
	task automatic send_bits(input logic [10:0] bits, input int n);
		wait (!tx_busy);
		tx_busy = 1'b1;
		for (int i = 0; i < n; i++) begin
			rx_o = bits[i];
			#(BIT_NS);
		end
		rx_o = 1'b0;
		tx_busy = 1'b0;
	endtask
	task automatic send_data(input logic [7:0] b);
		send_bits({1'b0, b, 2'b11}, 11);
	endtask
	always begin
		@(posedge tx_i);
		#(BIT_NS * 3 / 2);
		if (tx_i) begin
			for (int i = 0; i < 8; i++) begin
				#(BIT_NS);
				got_byte[i] = tx_i;
			end
			#(BIT_NS);
			n_data++;
			fork
				begin
					#(ack_wait * BIT_NS);
					send_bits(11'h001, 2);
				end
			join_none
		end else begin
			n_ack++;
		end
	end
endmodule

// *** testbench/tb.sv ***
// self-checking bench: handshake ports against the node model, then bus mode
// assumes the node model acknowledges every data byte it receives
`timescale 1ns/1ns
module tb import sla_pkg::*;;
	localparam int BC = int'(BIT_CYC_SLOW);
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic mode_speed_pin_i = 1'b1;
	logic bit_rate_pin_i = 1'b0;
	logic [7:0] in_port_byte_i = 8'h00;
	logic in_port_strobe_i = 1'b0;
	logic out_port_taken_i = 1'b0;
	logic chip_select_n_i = 1'b1;
	logic read_write_sel_i = 1'b1;
	logic [1:0] register_select_i = 2'h0;
	logic [7:0] m_d = 8'h00;
	logic m_oe = 1'b0;
	wire logic serial_rx_i;
	wire logic serial_tx_o;
	wire logic in_port_done_o;
	wire logic out_port_strobe_o;
	wire logic host_data_bus_oe_o;
	wire logic [7:0] peripheral_out_byte_o;
	wire logic [7:0] host_data_bus_o;
	wire logic [7:0] host_data_bus_i;
	wire logic [3:0] mon = {serial_tx_o, in_port_done_o, out_port_strobe_o, host_data_bus_oe_o};
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	// undriven bus shows a changing pattern, never the last value
	assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : (m_oe ? m_d : cyc[7:0]);
	sla_adaptor #(.FIFO_DEPTH(RX_FIFO_DEPTH)) i_dut (.core_clk_i, .reset_n_i, .serial_rx_i, .serial_tx_o,
		.mode_speed_pin_i, .bit_rate_pin_i, .in_port_byte_i, .in_port_strobe_i, .in_port_done_o,
		.peripheral_out_byte_o, .out_port_strobe_o, .out_port_taken_i, .host_data_bus_i, .host_data_bus_o,
		.host_data_bus_oe_o, .chip_select_n_i, .read_write_sel_i, .register_select_i);
	sla_node_model #(.BIT_NS(100)) i_node (.tx_i(serial_tx_o), .rx_o(serial_rx_i));
	always #2 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wait_lvl(input int idx, input logic lvl, output int n);
		n = 0;
		while (mon[idx] !== lvl && n < 2000) begin
			step(1);
			n++;
		end
		check(n < 2000, 1'b1);
	endtask
	task automatic do_reset(input logic mode);
		reset_n_i = 1'b0;
		mode_speed_pin_i = mode;
		step(16);
		check(mon, 4'h0);
		reset_n_i = 1'b1;
		step(140);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic in_port_case(input logic [7:0] b);
		int n;
		in_port_byte_i = b;
		step(1);
		in_port_strobe_i = 1'b1;
		wait_lvl(3, 1'b1, n);
		check(n >= 20 && n <= 50, 1'b1);
		wait_lvl(2, 1'b1, n);
		check(n <= (27 + 2 * i_node.ack_wait) * BC / 2, 1'b1);
		check(i_node.got_byte, b);
		in_port_strobe_i = 1'b0;
		wait_lvl(2, 1'b0, n);
		check(n >= BC && n <= 4 * BC, 1'b1);
		step(2);
	endtask
	task automatic out_port_case(input logic [7:0] b);
		int n;
		int a;
		a = i_node.n_ack;
		fork
			i_node.send_data(b);
		join_none
		wait_lvl(1, 1'b1, n);
		check(n >= 288, 1'b1);
		check(peripheral_out_byte_o, b);
		step(3);
		out_port_taken_i = 1'b1;
		wait_lvl(1, 1'b0, n);
		check(n >= 45, 1'b1);
		step(2 * BC);
		check(i_node.n_ack, a + 1);
		out_port_taken_i = 1'b0;
		step(11 * BC);
		check(peripheral_out_byte_o, b);
	endtask
	task automatic bus_acc(input logic [1:0] s, input logic r, input logic [7:0] d, input bit swap,
		output logic [7:0] q);
		register_select_i = s;
		read_write_sel_i = r;
		m_d = d;
		m_oe = !r;
		step(4);
		chip_select_n_i = 1'b0;
		step(4);
		if (swap) begin
			register_select_i = ~s;
			read_write_sel_i = !r;
		end
		step(4);
		q = host_data_bus_i;
		check(host_data_bus_oe_o, r);
		chip_select_n_i = 1'b1;
		step(4);
		m_oe = 1'b0;
		check(host_data_bus_oe_o, 1'b0);
		step(4);
	endtask
	task automatic bus_case();
		logic [7:0] q;
		int a;
		int n;
		bus_acc(REG_TX_STAT, 1'b1, 8'h00, 1'b1, q);
		check(q, 8'h01);
		bus_acc(REG_RX_STAT, 1'b1, 8'h00, 1'b0, q);
		check(q, 8'h00);
		a = i_node.n_data;
		bus_acc(REG_TX_DATA, 1'b0, 8'hC3, 1'b0, q);
		bus_acc(REG_TX_STAT, 1'b1, 8'h00, 1'b0, q);
		check(q, 8'h00);
		step(20 * BC);
		check(i_node.n_data, a + 1);
		check(i_node.got_byte, 8'hC3);
		bus_acc(REG_TX_STAT, 1'b1, 8'h00, 1'b0, q);
		check(q, 8'h01);
		fork
			i_node.send_data(8'h96);
		join_none
		step(14 * BC);
		bus_acc(REG_RX_STAT, 1'b1, 8'h00, 1'b0, q);
		check(q, 8'h01);
		bus_acc(REG_RX_DATA, 1'b0, 8'h11, 1'b0, q);
		a = i_node.n_ack;
		bus_acc(REG_RX_DATA, 1'b1, 8'h00, 1'b0, q);
		check(q, 8'h96);
		step(4 * BC);
		check(i_node.n_ack, a + 1);
		bus_acc(REG_RX_STAT, 1'b1, 8'h00, 1'b0, q);
		check(q, 8'h00);
		bus_acc(REG_RX_STAT, 1'b0, 8'h02, 1'b0, q);
		bus_acc(REG_RX_STAT, 1'b1, 8'h00, 1'b0, q);
		check(q, 8'h02);
		bus_acc(REG_TX_STAT, 1'b0, 8'h02, 1'b0, q);
		bus_acc(REG_TX_STAT, 1'b1, 8'h00, 1'b0, q);
		check(q, 8'h03);
		bus_acc(REG_TX_DATA, 1'b1, 8'h00, 1'b0, q);
		check(q, 8'h00);
		bit_rate_pin_i = 1'b1;
		bus_acc(REG_TX_DATA, 1'b0, 8'h5A, 1'b0, q);
		wait_lvl(3, 1'b1, n);
		wait_lvl(3, 1'b0, n);
		check(n, 2 * BIT_CYC_FAST);
	endtask
	initial begin
		do_reset(1'b1);
		in_port_case(8'hA5);
		in_port_case(8'h00);
		out_port_case(8'h5A);
		i_node.ack_wait = 3;
		in_port_case(8'hFF);
		out_port_case(8'hFF);
		do_reset(1'b0);
		bus_case();
		complete_run();
	end
endmodule
